/* src/pps_top.sv */
// Pack protection supervisor: current protections, scheduler, modes, gauge support.
// Assumes current, cell and temperature samples arrive from logic on clk.
module pps_top
  import pps_pkg::*;
#(
  parameter int MS_CYCLES = US_CYCLES * MS_US,
  parameter int AUTOCAL_MS = AUTOCAL_IDLE_MS
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic signed [15:0] sense_sample,
  input wire logic sense_valid,
  input wire logic [NCELL*16-1:0] cell_raw,
  input wire logic cell_valid,
  input wire logic signed [15:0] int_temp,
  input wire logic signed [15:0] ext_temp,
  input wire logic auth_ok,
  input wire logic bus_activity,
  output logic charge_fet_gate,
  output logic discharge_fet_gate,
  output logic meas_cycle,
  output logic cell_sample_req,
  output logic autocal_start,
  output logic charging,
  output logic discharging,
  output logic charge_inhibit,
  output logic [15:0] charge_voltage,
  output logic [15:0] charge_current,
  output logic int_temp_en,
  output logic ext_temp_en,
  output logic [3:0] int_temp_cfg,
  output logic [3:0] ext_temp_cfg,
  output logic [NCELL*16-1:0] cell_cal,
  output logic [NPROT-1:0] fault_flags
);

  typedef struct packed {
    logic [1:0] ctrl;
    logic [3:0] tune;
    logic [NPROT-1:0][31:0] setup;
    logic [NPROT-1:0] fault;
    logic [NPROT-1:0][DLY_W-1:0] cnt;
    logic [1:0] mode;
    logic [15:0] sleep_ms;
    logic [31:0] coulomb;
    logic signed [15:0] current;
    logic [11:0] tcfg;
    logic [31:0] twin;
    logic sealed;
    logic [NBOUND-1:0][15:0] bound;
    logic [NRANGE-1:0][31:0] profile;
    logic [NCELL-1:0][15:0] cell_ofs;
    logic [NCELL-1:0][15:0] cal;
    logic [31:0] us_cnt;
    logic [31:0] ms_cnt;
    logic [15:0] per_cnt;
    logic [31:0] idle_cnt;
    logic cal_done;
    logic cal_pulse;
    logic cyc_pulse;
    logic inhibit;
    logic [2:0] range;
    logic [31:0] charge_prof;
    logic cgate_on;
    logic dgate_on;
    logic sync1;
    logic sync2;
    logic ack;
    logic [31:0] rdata;
  } pps_state_t;

  pps_state_t s_q;
  pps_state_t s_d;

  // ==========================================================
  // Decode helpers
  function automatic logic in_block(input logic [7:0] a, input logic [7:0] base,
                                    input int n);
    in_block = (a >= base) && (a < base + 8'(4 * n)) && (a[1:0] == 2'h0);
  endfunction

  function automatic int word_idx(input logic [7:0] a, input logic [7:0] base);
    word_idx = int'(8'(a - base) >> 2);
  endfunction

  logic bus_take;
  logic us_tick;
  logic ms_tick;
  logic active;
  logic [15:0] thr_eff [NPROT];
  logic [DLY_W-1:0] dly_eff [NPROT];
  logic [NPROT-1:0] cond;
  logic [NPROT-1:0] trip;
  logic [NPROT-1:0] clr;
  logic signed [16:0] cur_wide;
  logic signed [16:0] cur_neg;
  logic signed [15:0] temp_sel;
  logic [15:0] period;
  logic [2:0] rng;
  logic [31:0] rd;

  assign avs_waitrequest = (avs_read | avs_write) & ~s_q.ack;
  assign bus_take = (avs_read | avs_write) & s_q.ack;

  always_comb begin
    s_d = s_q;
    rd = 32'h0;
    rng = 3'h0;
    clr = '0;
    trip = '0;
    cond = '0;
    active = (s_q.mode != MODE_SHUTDOWN);
    cur_wide = {s_q.current[15], s_q.current};
    cur_neg = -cur_wide;
    // ==========================================================
    // Bus pin synchroniser and time base
    s_d.sync1 = bus_activity;
    s_d.sync2 = s_q.sync1;
    // One-cycle tick enables from the single clock
    us_tick = (s_q.us_cnt == 32'(US_CYCLES - 1));
    s_d.us_cnt = us_tick ? 32'h0 : s_q.us_cnt + 32'h1;
    ms_tick = us_tick && (s_q.ms_cnt == 32'(MS_CYCLES / US_CYCLES - 1));
    if (us_tick) begin
      s_d.ms_cnt = ms_tick ? 32'h0 : s_q.ms_cnt + 32'h1;
    end
    // ==========================================================
    // Measurement scheduler
    period = (s_q.mode == MODE_SLEEP) ? s_q.sleep_ms : 16'(NORMAL_PERIOD_MS);
    if (period == 16'h0) begin
      period = 16'h1;
    end
    s_d.cyc_pulse = 1'b0;
    if (!active) begin
      s_d.per_cnt = 16'h0;
    end else if (ms_tick) begin
      if (s_q.per_cnt + 16'h1 >= period) begin
        s_d.per_cnt = 16'h0;
        s_d.cyc_pulse = 1'b1;
      end else begin
        s_d.per_cnt = s_q.per_cnt + 16'h1;
      end
    end
    // ==========================================================
    // Sense sampling and coulomb accumulation
    if (active && sense_valid) begin
      s_d.current = sense_sample;
      s_d.coulomb = s_q.coulomb + 32'(sense_sample);
    end
    // ==========================================================
    // Current protections
    for (int i = 0; i < NPROT; i++) begin
      thr_eff[i] = s_q.setup[i][F_THR_LSB +: 16] >> s_q.tune[F_TUNE_THR_LSB +: 2];
      dly_eff[i] = DLY_W'({4'h0, s_q.setup[i][F_DLY_LSB +: 16]}
                          << s_q.tune[F_TUNE_DLY_LSB +: 2]);
      if (i == P_CHARGE_SHORT) begin
        cond[i] = active && (cur_wide > signed'({1'b0, thr_eff[i]}));
      end else begin
        cond[i] = active && (cur_neg > signed'({1'b0, thr_eff[i]}));
      end
      // Counter holds at the delay; trip repeats while condition stays
      if (!cond[i]) begin
        s_d.cnt[i] = '0;
      end else if (s_q.cnt[i] >= dly_eff[i]) begin
        trip[i] = 1'b1;
      end else if (us_tick) begin
        s_d.cnt[i] = s_q.cnt[i] + DLY_W'(1);
      end
    end
    // ==========================================================
    // Measurement cycle data updates
    temp_sel = s_q.tcfg[F_TEXT_EN] ? ext_temp : int_temp;
    for (int b = 0; b < NBOUND; b++) begin
      if (temp_sel >= signed'(s_q.bound[b])) begin
        rng = rng + 3'h1;
      end
    end
    if (s_q.cyc_pulse) begin
      s_d.range = rng;
      s_d.charge_prof = s_q.profile[rng];
      s_d.inhibit = (temp_sel < signed'(s_q.twin[15:0]))
                    || (temp_sel > signed'(s_q.twin[31:16]));
    end
    if (active && cell_valid) begin
      for (int c = 0; c < NCELL; c++) begin
        s_d.cal[c] = cell_raw[c*16 +: 16] - s_q.cell_ofs[c];
      end
    end
    // ==========================================================
    // Auto-calibration idle watch
    s_d.cal_pulse = 1'b0;
    if (s_q.sync2) begin
      s_d.idle_cnt = 32'h0;
      s_d.cal_done = 1'b0;
    end else if (ms_tick && !s_q.cal_done && active) begin
      if (s_q.idle_cnt + 32'h1 >= 32'(AUTOCAL_MS)) begin
        s_d.cal_pulse = 1'b1;
        s_d.cal_done = 1'b1;
      end else begin
        s_d.idle_cnt = s_q.idle_cnt + 32'h1;
      end
    end
    // ==========================================================
    // Register slave
    s_d.ack = (avs_read | avs_write) & ~s_q.ack;
    // Sealed state ignores writes to protection and charge settings
    if (avs_write && bus_take) begin
      case (avs_address)
        A_FRONT_END_CONTROL: s_d.ctrl = avs_writedata[1:0];
        A_PROT_TUNE: if (!s_q.sealed) s_d.tune = avs_writedata[3:0];
        A_FAULT: clr = avs_writedata[NPROT-1:0];
        A_MODE: begin
          s_d.mode = avs_writedata[F_MODE_LSB +: 2];
          s_d.sleep_ms = avs_writedata[F_SLEEP_LSB +: 16];
        end
        A_TEMP_CFG: s_d.tcfg = avs_writedata[11:0];
        A_TEMP_WINDOW: if (!s_q.sealed) s_d.twin = avs_writedata;
        A_SEAL: begin
          if (avs_writedata[F_SEAL_SET]) begin
            s_d.sealed = 1'b1;
          end else if (avs_writedata[F_SEAL_OPEN] && auth_ok) begin
            s_d.sealed = 1'b0;
          end
        end
        default: begin
          if (!s_q.sealed && in_block(avs_address, A_SETUP_BASE, NPROT)) begin
            s_d.setup[word_idx(avs_address, A_SETUP_BASE)] = avs_writedata;
          end
          if (in_block(avs_address, A_CELL_OFS_BASE, NCELL)) begin
            s_d.cell_ofs[word_idx(avs_address, A_CELL_OFS_BASE)] = avs_writedata[15:0];
          end
          if (!s_q.sealed && in_block(avs_address, A_BOUND_BASE, NBOUND)) begin
            s_d.bound[word_idx(avs_address, A_BOUND_BASE)] = avs_writedata[15:0];
          end
          if (!s_q.sealed && in_block(avs_address, A_PROFILE_BASE, NRANGE)) begin
            s_d.profile[word_idx(avs_address, A_PROFILE_BASE)] = avs_writedata;
          end
        end
      endcase
    end
    // Set wins over clear; live condition re-latches a cleared flag
    s_d.fault = (s_q.fault & ~clr) | trip | (s_q.fault & clr & cond);
    s_d.cgate_on = active && s_q.ctrl[F_CHARGE_EN] && (s_d.fault == '0);
    s_d.dgate_on = active && s_q.ctrl[F_DISCHARGE_EN] && (s_d.fault == '0);
    // Read mux; unmapped addresses return zero
    case (avs_address)
      A_FRONT_END_CONTROL: rd = {30'h0, s_q.ctrl};
      A_PROT_TUNE: rd = {28'h0, s_q.tune};
      A_FAULT: rd = {28'h0, s_q.fault};
      A_STATUS: rd = {22'h0, s_q.range, s_q.inhibit, s_q.sealed,
                      cur_neg > 17'sh0, cur_wide > 17'sh0,
                      s_q.dgate_on, s_q.cgate_on, active};
      A_MODE: rd = {s_q.sleep_ms, 14'h0, s_q.mode};
      A_COULOMB: rd = s_q.coulomb;
      A_TEMP_CFG: rd = {20'h0, s_q.tcfg};
      A_TEMP_WINDOW: rd = s_q.twin;
      A_SEAL: rd = {31'h0, s_q.sealed};
      default: begin
        if (in_block(avs_address, A_SETUP_BASE, NPROT)) begin
          rd = s_q.setup[word_idx(avs_address, A_SETUP_BASE)];
        end
        if (in_block(avs_address, A_CELL_OFS_BASE, NCELL)) begin
          rd = {16'h0, s_q.cell_ofs[word_idx(avs_address, A_CELL_OFS_BASE)]};
        end
        if (in_block(avs_address, A_BOUND_BASE, NBOUND)) begin
          rd = {16'h0, s_q.bound[word_idx(avs_address, A_BOUND_BASE)]};
        end
        if (in_block(avs_address, A_PROFILE_BASE, NRANGE)) begin
          rd = s_q.profile[word_idx(avs_address, A_PROFILE_BASE)];
        end
        if (in_block(avs_address, A_CELL_CAL_BASE, NCELL)) begin
          rd = {16'h0, s_q.cal[word_idx(avs_address, A_CELL_CAL_BASE)]};
        end
      end
    endcase
    if (avs_read && !s_q.ack) begin
      s_d.rdata = rd;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
      s_q.ctrl <= RST_CTRL;
      s_q.sleep_ms <= RST_SLEEP_MS;
      s_q.tcfg <= RST_TEMP_CFG;
      s_q.twin <= RST_TEMP_WINDOW;
      s_q.sealed <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================
  // Outputs
  assign avs_readdata = s_q.rdata;
  assign charge_fet_gate = s_q.cgate_on;
  assign discharge_fet_gate = s_q.dgate_on;
  assign meas_cycle = s_q.cyc_pulse;
  assign cell_sample_req = s_q.cyc_pulse;
  assign autocal_start = s_q.cal_pulse;
  assign charging = active && (s_q.current > 16'sh0);
  assign discharging = active && (s_q.current < 16'sh0);
  assign charge_inhibit = s_q.inhibit;
  assign charge_voltage = s_q.charge_prof[31:16];
  assign charge_current = s_q.charge_prof[15:0];
  assign int_temp_en = s_q.tcfg[F_TINT_EN];
  assign ext_temp_en = s_q.tcfg[F_TEXT_EN];
  assign int_temp_cfg = s_q.tcfg[F_TINT_CFG_LSB +: 4];
  assign ext_temp_cfg = s_q.tcfg[F_TEXT_CFG_LSB +: 4];
  assign cell_cal = s_q.cal;
  assign fault_flags = s_q.fault;

endmodule // pps_top

/* include/pps_pkg.sv */
// Constants, register map and state encodings for the pack protection supervisor.
// Assumes a single 125 MHz clock and a 32-bit Avalon-MM register port.
package pps_pkg;

  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int US_NS = 1000;
  localparam int US_CYCLES = (US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MS_US = 1000;
  localparam int NORMAL_PERIOD_MS = 250;
  localparam int AUTOCAL_IDLE_S = 5;
  localparam int S_MS = 1000;
  localparam int AUTOCAL_IDLE_MS = AUTOCAL_IDLE_S * S_MS;

  // ==========================================================
  // Sizes
  localparam int NPROT = 4;
  localparam int NCELL = 2;
  localparam int NBOUND = 5;
  localparam int NRANGE = 6;
  localparam int DLY_W = 20;

  // ==========================================================
  // Protection indices
  localparam int P_DCH_OVERCURRENT = 0;
  localparam int P_CHARGE_SHORT = 1;
  localparam int P_DCH_SHORT_ONE = 2;
  localparam int P_DCH_SHORT_TWO = 3;

  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] A_FRONT_END_CONTROL = 8'h00;
  localparam logic [7:0] A_PROT_TUNE = 8'h04;
  localparam logic [7:0] A_SETUP_BASE = 8'h08;
  localparam logic [7:0] A_FAULT = 8'h18;
  localparam logic [7:0] A_STATUS = 8'h1C;
  localparam logic [7:0] A_MODE = 8'h20;
  localparam logic [7:0] A_COULOMB = 8'h24;
  localparam logic [7:0] A_TEMP_CFG = 8'h28;
  localparam logic [7:0] A_TEMP_WINDOW = 8'h2C;
  localparam logic [7:0] A_SEAL = 8'h30;
  localparam logic [7:0] A_CELL_OFS_BASE = 8'h34;
  localparam logic [7:0] A_BOUND_BASE = 8'h40;
  localparam logic [7:0] A_PROFILE_BASE = 8'h60;
  localparam logic [7:0] A_CELL_CAL_BASE = 8'h80;

  // ==========================================================
  // Field positions
  localparam int F_CHARGE_EN = 0;
  localparam int F_DISCHARGE_EN = 1;
  localparam int F_THR_LSB = 0;
  localparam int F_DLY_LSB = 16;
  localparam int F_TUNE_THR_LSB = 0;
  localparam int F_TUNE_DLY_LSB = 2;
  localparam int F_MODE_LSB = 0;
  localparam int F_SLEEP_LSB = 16;
  localparam int F_SEAL_SET = 0;
  localparam int F_SEAL_OPEN = 1;
  localparam int F_TINT_EN = 0;
  localparam int F_TEXT_EN = 1;
  localparam int F_TINT_CFG_LSB = 4;
  localparam int F_TEXT_CFG_LSB = 8;

  // ==========================================================
  // Mode field encodings and reset values
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_SLEEP = 2'h1;
  localparam logic [1:0] MODE_SHUTDOWN = 2'h2;
  localparam logic [1:0] RST_CTRL = 2'h3;
  localparam logic [15:0] RST_SLEEP_MS = 16'h1388;
  localparam logic [11:0] RST_TEMP_CFG = 12'h003;
  localparam logic [31:0] RST_TEMP_WINDOW = 32'h01C20000;

endpackage

/* tb/pps_sva.sv */
// Concurrent checks on the pack protection supervisor ports.
// Bound into pps_top; sees its ports only, single clock domain.
module pps_sva
  import pps_pkg::*;
#(
  parameter int MS_CYCLES = US_CYCLES * MS_US,
  parameter int AUTOCAL_MS = AUTOCAL_IDLE_MS
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic avs_waitrequest,
  input wire logic bus_activity,
  input wire logic charge_fet_gate,
  input wire logic discharge_fet_gate,
  input wire logic meas_cycle,
  input wire logic cell_sample_req,
  input wire logic autocal_start,
  input wire logic charging,
  input wire logic discharging,
  input wire logic [NPROT-1:0] fault_flags
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int IDLE_MIN = (AUTOCAL_MS - 1) * MS_CYCLES;
  // ==========================================================
  // Shadow of bus writes and bus idle time
  logic [1:0] ctrl_q;
  logic [1:0] mode_q;
  logic wrf_q;
  int idle_q;
  logic acc;
  assign acc = avs_write & ~avs_waitrequest;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_q <= 2'h3;
      mode_q <= MODE_NORMAL;
      wrf_q <= 1'b0;
      idle_q <= 0;
    end else begin
      if (acc && avs_address == A_FRONT_END_CONTROL) ctrl_q <= avs_writedata[1:0];
      if (acc && avs_address == A_MODE) mode_q <= avs_writedata[1:0];
      wrf_q <= acc && avs_address == A_FAULT;
      idle_q <= bus_activity ? 0 : idle_q + 1;
    end
  end
  // ==========================================================
  // Assertions
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  gates_off_a: assert property (|fault_flags |-> !charge_fet_gate && !discharge_fet_gate)
    else $error("gate on while a fault flag is set");
  flag_clear_a: assert property ((($past(fault_flags) & ~fault_flags) != '0) |-> wrf_q)
    else $error("fault flag dropped without a clear write");
  meas_pulse_a: assert property (meas_cycle |=> !meas_cycle)
    else $error("measurement pulse longer than one cycle");
  cell_pair_a: assert property (meas_cycle == cell_sample_req)
    else $error("cell sample request not with measurement pulse");
  shut_idle_a: assert property (mode_q == MODE_SHUTDOWN |=> !meas_cycle && !charge_fet_gate)
    else $error("activity in shutdown");
  gate_force_a: assert property (ctrl_q == 2'h0 |=> !charge_fet_gate && !discharge_fet_gate)
    else $error("gate on with both enables cleared");
  cal_idle_a: assert property (autocal_start |-> idle_q >= IDLE_MIN)
    else $error("autocal started before bus idle time");
  cal_once_a: assert property (autocal_start |=> !autocal_start [*8])
    else $error("autocal pulse repeated");
  sign_excl_a: assert property (charging |-> !discharging)
    else $error("charging and discharging together");
  bus_wait_a: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("bus answer not after one wait cycle");
  meas_c: cover property (meas_cycle);
  cal_c: cover property (autocal_start);
  fault_c: cover property (|fault_flags);
endmodule // pps_sva

bind pps_top pps_sva #(.MS_CYCLES(MS_CYCLES), .AUTOCAL_MS(AUTOCAL_MS)) u_sva (
  .clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_waitrequest(avs_waitrequest),
  .bus_activity(bus_activity), .charge_fet_gate(charge_fet_gate),
  .discharge_fet_gate(discharge_fet_gate), .meas_cycle(meas_cycle),
  .cell_sample_req(cell_sample_req), .autocal_start(autocal_start), .charging(charging),
  .discharging(discharging), .fault_flags(fault_flags));

/* tb/pps_fet_model.sv */
// Behavioural back-to-back N-channel protection FET pair.
// Gates come from pps_top; a released gate is pulled to its source.
module pps_fet_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic charge_fet_gate,
  input wire logic discharge_fet_gate,
  output logic cfet_on,
  output logic dfet_on
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] c_q;
  logic [1:0] d_q;
  // Slow turn-on from gate charge, instant turn-off via pull-down
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      c_q <= 2'h0;
      d_q <= 2'h0;
    end else begin
      c_q <= {c_q[0], charge_fet_gate};
      d_q <= {d_q[0], discharge_fet_gate};
    end
  end
  assign cfet_on = c_q[1] & charge_fet_gate;
  assign dfet_on = d_q[1] & discharge_fet_gate;
endmodule // pps_fet_model

/* tb/tb_top.sv */
// Self-checking bench for pps_top with a FET pair model on the gates.
// Assumes shortened ms tick (250 cycles) and 3 ms autocal idle.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import pps_pkg::*;
  localparam int MSC = 250;
  localparam int ACM = 3;
  logic clk, rst, avs_read, avs_write, avs_waitrequest, sense_valid, cell_valid, auth_ok;
  logic bus_activity, charge_fet_gate, discharge_fet_gate, meas_cycle, cell_sample_req;
  logic autocal_start, charging, discharging, charge_inhibit, int_temp_en, ext_temp_en;
  logic cfet_on, dfet_on;
  logic [7:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rq;
  logic signed [15:0] sense_sample, int_temp, ext_temp;
  logic [NCELL*16-1:0] cell_raw, cell_cal;
  logic [15:0] charge_voltage, charge_current;
  logic [3:0] int_temp_cfg, ext_temp_cfg;
  logic [NPROT-1:0] fault_flags;
  int fails, cmp_count, cyc, n;
  pps_top #(.MS_CYCLES(MSC), .AUTOCAL_MS(ACM)) dut (.clk(clk), .rst(rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .sense_sample(sense_sample), .sense_valid(sense_valid),
    .cell_raw(cell_raw), .cell_valid(cell_valid), .int_temp(int_temp), .ext_temp(ext_temp),
    .auth_ok(auth_ok), .bus_activity(bus_activity), .charge_fet_gate(charge_fet_gate),
    .discharge_fet_gate(discharge_fet_gate), .meas_cycle(meas_cycle),
    .cell_sample_req(cell_sample_req), .autocal_start(autocal_start), .charging(charging),
    .discharging(discharging), .charge_inhibit(charge_inhibit),
    .charge_voltage(charge_voltage), .charge_current(charge_current),
    .int_temp_en(int_temp_en), .ext_temp_en(ext_temp_en), .int_temp_cfg(int_temp_cfg),
    .ext_temp_cfg(ext_temp_cfg), .cell_cal(cell_cal), .fault_flags(fault_flags));
  pps_fet_model fet (.clk(clk), .rst(rst), .charge_fet_gate(charge_fet_gate),
    .discharge_fet_gate(discharge_fet_gate), .cfet_on(cfet_on), .dfet_on(dfet_on));
  // ==========================================================
  // Clock, timeout, reporting
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 95000) begin
      fails++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    chk32({31'h0, got}, {31'h0, exp});
  endtask
  // ==========================================================
  // Bus and stimulus helpers
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    rq = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk);
  endtask
  task automatic w(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic r(input logic [7:0] a);
    bus(1'b0, a, 32'h0);
  endtask
  task automatic sense(input logic signed [15:0] v);
    sense_sample <= v;
    sense_valid <= 1'b1;
    @(posedge clk);
    sense_valid <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wait_meas();
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (meas_cycle !== 1'b1);
    repeat (3) @(posedge clk);
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_reset();
    logic [7:0] ad [6] = '{A_FRONT_END_CONTROL, A_MODE, A_TEMP_CFG, A_TEMP_WINDOW, A_SEAL, 8'hFC};
    logic [31:0] ex [6] = '{32'h3, 32'h13880000, 32'h3, RST_TEMP_WINDOW, 32'h1, 32'h0};
    wait_meas();
    chk1(n >= 250 * MSC - 4 && n <= 250 * MSC + 4, 1'b1);
    for (int i = 0; i < 6; i++) begin
      r(ad[i]);
      chk32(rq, ex[i]);
    end
    chk1(cfet_on & dfet_on, 1'b1);
    $display("t_reset done at %0t", $time);
  endtask
  task automatic t_seal();
    w(A_SETUP_BASE, 32'h00000064);
    r(A_SETUP_BASE);
    chk32(rq, 32'h0);
    w(A_SEAL, 32'h2);
    r(A_SEAL);
    chk32(rq, 32'h1);
    auth_ok <= 1'b1;
    w(A_SEAL, 32'h2);
    r(A_SEAL);
    chk32(rq, 32'h0);
    w(A_FRONT_END_CONTROL, 32'h0);
    repeat (3) @(posedge clk);
    chk1(charge_fet_gate | discharge_fet_gate | dfet_on, 1'b0);
    w(A_FRONT_END_CONTROL, 32'h3);
    repeat (3) @(posedge clk);
    chk1(charge_fet_gate & discharge_fet_gate, 1'b1);
    $display("t_seal done at %0t", $time);
  endtask
  task automatic t_prot();
    for (int i = 0; i < NPROT; i++) begin
      for (int j = 0; j < NPROT; j++)
        w(A_SETUP_BASE + 8'(4 * j), (i == j) ? 32'h00030064 : 32'h00007FFF);
      sense((i == P_CHARGE_SHORT) ? 16'sh00C8 : -16'sh00C8);
      repeat (240) @(posedge clk);
      chk1(fault_flags[i], 1'b0);
      repeat (160) @(posedge clk);
      chk32({28'h0, fault_flags}, 32'(1 << i));
      chk1(charge_fet_gate | discharge_fet_gate | cfet_on, 1'b0);
      w(A_FAULT, 32'(1 << i));
      chk1(fault_flags[i], 1'b1);
      sense(16'sh0000);
      w(A_FAULT, 32'(1 << i));
      repeat (3) @(posedge clk);
      chk32({26'h0, fault_flags, charge_fet_gate, discharge_fet_gate}, 32'h3);
    end
    w(A_PROT_TUNE, 32'h1);
    w(A_SETUP_BASE, 32'h0000012C);
    sense(-16'sh00C8);
    repeat (4) @(posedge clk);
    chk1(fault_flags[P_DCH_OVERCURRENT], 1'b1);
    chk1(discharging & ~charging, 1'b1);
    sense(16'sh0005);
    chk1(charging & ~discharging, 1'b1);
    r(A_COULOMB);
    chk32(rq, 32'hFFFFFDAD);
    w(A_FAULT, 32'hF);
    w(A_PROT_TUNE, 32'h0);
    $display("t_prot done at %0t", $time);
  endtask
  task automatic t_cell();
    w(A_CELL_OFS_BASE, 32'h10);
    cell_raw <= {16'h0200, 16'h0100};
    cell_valid <= 1'b1;
    @(posedge clk);
    cell_valid <= 1'b0;
    repeat (3) @(posedge clk);
    chk32(cell_cal, 32'h020000F0);
    $display("t_cell done at %0t", $time);
  endtask
  task automatic t_modes();
    int k;
    k = 0;
    w(A_MODE, {16'h0004, 14'h0, MODE_SLEEP});
    wait_meas();
    wait_meas();
    chk1(n + 3 >= 4 * MSC - 3 && n + 3 <= 4 * MSC + 3, 1'b1);
    w(A_MODE, {30'h0, MODE_SHUTDOWN});
    repeat (3000) begin
      @(posedge clk);
      if (meas_cycle === 1'b1) k++;
    end
    chk32(k, 0);
    chk1(charge_fet_gate | dfet_on, 1'b0);
    w(A_MODE, {16'h0001, 14'h0, MODE_SLEEP});
    $display("t_modes done at %0t", $time);
  endtask
  task automatic t_temp();
    ext_temp <= 16'sd500;
    w(A_BOUND_BASE + 8'h10, 32'h000000C8);
    w(A_PROFILE_BASE + 8'h10, 32'h10680BB8);
    wait_meas();
    wait_meas();
    chk1(charge_inhibit, 1'b1);
    chk32({charge_voltage, charge_current}, 32'h0);
    ext_temp <= 16'sd100;
    wait_meas();
    wait_meas();
    chk1(charge_inhibit, 1'b0);
    chk32({charge_voltage, charge_current}, 32'h10680BB8);
    w(A_TEMP_CFG, 32'h5A1);
    repeat (2) @(posedge clk);
    chk32({22'h0, int_temp_en, ext_temp_en, int_temp_cfg, ext_temp_cfg}, 32'h2A5);
    $display("t_temp done at %0t", $time);
  endtask
  task automatic t_cal();
    bus_activity <= 1'b1;
    repeat (10) @(posedge clk);
    bus_activity <= 1'b0;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (autocal_start !== 1'b1);
    chk1(n >= (ACM - 1) * MSC && n <= ACM * MSC + 6, 1'b1);
    repeat (1000) @(posedge clk);
    $display("t_cal done at %0t", $time);
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    {avs_read, avs_write, sense_valid, cell_valid, auth_ok, bus_activity} = 6'h0;
    avs_address = 8'h0;
    avs_writedata = 32'h0;
    sense_sample = 16'sh0000;
    int_temp = 16'sd100;
    ext_temp = 16'sd100;
    cell_raw = '0;
    fails = 0;
    cmp_count = 0;
    cyc = 0;
    rst = 1'b1;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_seal();
    t_prot();
    t_cell();
    t_modes();
    t_temp();
    t_cal();
    tally_and_finish();
  end
endmodule // tb_top
